// *** hdl/rrs_exec.sv ***
/*
  Execute block for the rotate-right-through-carry and sleep instructions.
  Assumes the core presents one fetched word per instruction cycle with
  instr_valid high, gives the addressed file register value on file_rdata
  in the same cycle, and accepts write strobes one cycle after execution.
  The watchdog prescaler and counter tick here on the core clock while awake.
*/
`timescale 1ns/100ps
module rrs_exec (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  file_rdata,
  input  wire logic        wake_event,
  output logic      [4:0]  file_raddr,
  output logic      [4:0]  file_waddr_q,
  output logic      [7:0]  file_wdata_q,
  output logic             file_we_q,
  output logic      [7:0]  working_q,
  output logic             working_we_q,
  output logic             carry_q,
  output logic             timeout_status_flag_q,
  output logic             powerdown_status_flag_q,
  output logic             wake_status_flag_q,
  output logic      [7:0]  watchdog_counter_q,
  output logic      [7:0]  watchdog_presc_q,
  output logic             halted_q,
  output logic             osc_run_q
);
  typedef enum logic [1:0] {
    RRS_RUN   = 2'b01,
    RRS_SLEEP = 2'b10
  } rrs_state_e;

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       wake_meta_q;
  logic       wake_sync_q;
  rrs_state_e state_q;
  logic       is_rotate;
  logic       is_sleep;
  logic       dest_file;
  logic [7:0] rot_result;
  logic       rot_carry;
  logic       run_ok;
  logic       rot_match;
  logic       sleep_match;
  logic       presc_wrap;

  // Reset is released through two flops so the core leaves reset cleanly.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // The wake source is asynchronous to the core, so it is synchronised first.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_event;
      wake_sync_q <= wake_meta_q;
    end
  end

  // Decoding is gated by the run state so nothing executes while asleep.
  always_comb begin
    run_ok      = instr_valid && (state_q == RRS_RUN);
    rot_match   = (instr_word & rrs_pkg::ROT_MASK) == rrs_pkg::ROT_MATCH;
    sleep_match = instr_word == rrs_pkg::SLEEP_OPCODE;
    is_rotate   = run_ok && rot_match;
    is_sleep    = run_ok && sleep_match;
    dest_file   = instr_word[rrs_pkg::DEST_BIT];
    // The read address is decoded straight from the word and not registered, because
    // the register file must answer within the same cycle for a one-cycle rotate.
    file_raddr  = instr_word[rrs_pkg::FADDR_LSB +: rrs_pkg::FADDR_W];
  end

  rrs_rotate u_rotate (
    .operand   (file_rdata),
    .carry_in  (carry_q),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // Result lands in one cycle; only carry among the status bits changes.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      carry_q <= rrs_pkg::CARRY_RESET;
    end else if (is_rotate) begin
      carry_q <= rot_carry;
    end
  end

  // The file write port carries a one-cycle strobe beside a held address and data.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      file_we_q    <= 1'b0;
      file_waddr_q <= '0;
      file_wdata_q <= '0;
    end else begin
      file_we_q <= is_rotate && dest_file;
      if (is_rotate) begin
        file_waddr_q <= file_raddr;
        file_wdata_q <= rot_result;
      end
    end
  end

  // The working register copy changes only for a rotate aimed at it.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      working_we_q <= 1'b0;
      working_q    <= '0;
    end else begin
      working_we_q <= is_rotate && (dest_file == rrs_pkg::DEST_W);
      if (is_rotate && (dest_file == rrs_pkg::DEST_W)) begin
        working_q <= rot_result;
      end
    end
  end

  // Flag polarity follows the core: timeout and power-down read high after reset.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      timeout_status_flag_q <= rrs_pkg::TO_RESET;
    end else if (is_sleep) begin
      timeout_status_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      powerdown_status_flag_q <= rrs_pkg::PD_RESET;
    end else if (is_sleep) begin
      powerdown_status_flag_q <= 1'b0;
    end
  end

  // Only reset clears the wake flag; sleep sets it and the wake-up path leaves it set.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wake_status_flag_q <= rrs_pkg::WAKE_RESET;
    end else if (is_sleep) begin
      wake_status_flag_q <= 1'b1;
    end
  end

  // The prescaler runs on the core clock while awake and carries into the counter.
  // Both are held while asleep, since this block has no clock once the oscillator
  // stops; a free-running watchdog oscillator would have to live elsewhere.
  always_comb begin
    presc_wrap = &watchdog_presc_q;
  end

  // Sleep clears both stages on the same edge, and the clear wins over a tick.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      watchdog_presc_q <= rrs_pkg::PRESC_CLEAR;
    end else if (is_sleep) begin
      watchdog_presc_q <= rrs_pkg::PRESC_CLEAR;
    end else if (state_q == RRS_RUN) begin
      watchdog_presc_q <= watchdog_presc_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      watchdog_counter_q <= rrs_pkg::WDT_CLEAR;
    end else if (is_sleep) begin
      watchdog_counter_q <= rrs_pkg::WDT_CLEAR;
    end else if ((state_q == RRS_RUN) && presc_wrap) begin
      watchdog_counter_q <= watchdog_counter_q + 8'h01;
    end
  end

  // Wake handling is minimal: a synchronised wake level resumes execution.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q   <= RRS_RUN;
      halted_q  <= 1'b0;
      osc_run_q <= 1'b1;
    end else begin
      unique case (state_q)
        RRS_RUN: begin
          if (is_sleep) begin
            state_q   <= RRS_SLEEP;
            halted_q  <= 1'b1;
            osc_run_q <= 1'b0;
          end
        end
        RRS_SLEEP: begin
          if (wake_sync_q) begin
            state_q   <= RRS_RUN;
            halted_q  <= 1'b0;
            osc_run_q <= 1'b1;
          end
        end
        // An illegal state code falls back to run so the core cannot stay stuck.
        default: begin
          state_q   <= RRS_RUN;
          halted_q  <= 1'b0;
          osc_run_q <= 1'b1;
        end
      endcase
    end
  end
endmodule : rrs_exec

// *** hdl/rrs_pkg.sv ***
/*
  Constants for the rotate-right and sleep execute block: opcode patterns,
  field positions, widths and reset values.
  Assumes a 12-bit program word and an 8-bit data path.
*/
package rrs_pkg;
  localparam int unsigned INSTR_W       = 12;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned FADDR_W       = 5;
  localparam int unsigned WDT_W         = 8;
  localparam int unsigned PRESC_W       = 8;
  localparam logic [11:0] ROT_MASK      = 12'hFC0;
  localparam logic [11:0] ROT_MATCH     = 12'h300;
  localparam logic [11:0] SLEEP_OPCODE  = 12'h003;
  localparam int unsigned DEST_BIT      = 5;
  localparam int unsigned FADDR_LSB     = 0;
  localparam int unsigned MSB_POS       = 7;
  localparam logic [7:0]  WDT_CLEAR     = 8'h00;
  localparam logic [7:0]  PRESC_CLEAR   = 8'h00;
  localparam logic        TO_RESET      = 1'b1;
  localparam logic        PD_RESET      = 1'b1;
  localparam logic        WAKE_RESET    = 1'b0;
  localparam logic        CARRY_RESET   = 1'b0;
  localparam logic        DEST_W        = 1'b0;
endpackage : rrs_pkg

// *** hdl/rrs_rotate.sv ***
/*
  Combinational right rotation of one byte through a carry bit.
  Assumes operands come from registers on the caller's clock.
*/
`timescale 1ns/100ps
module rrs_rotate (
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);
  always_comb begin
    result    = {carry_in, operand[rrs_pkg::MSB_POS:1]};
    carry_out = operand[0];
  end
endmodule : rrs_rotate

// *** verif/rrs_exec_asserts.sv ***
/* Checker for rrs_exec: outcome of each taken rotate or sleep word.
   Assumes a bind to rrs_exec and its single clock domain. */
`timescale 1ns/100ps
module rrs_exec_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata_q,
  input wire logic [7:0]  working_q,
  input wire logic [7:0]  watchdog_counter_q,
  input wire logic [7:0]  watchdog_presc_q,
  input wire logic [4:0]  file_waddr_q,
  input wire logic        file_we_q,
  input wire logic        working_we_q,
  input wire logic        carry_q,
  input wire logic        halted_q,
  input wire logic        osc_run_q,
  input wire logic        timeout_status_flag_q,
  input wire logic        powerdown_status_flag_q,
  input wire logic        wake_status_flag_q
);
  logic go, rot, slp;
  assign go  = instr_valid && !halted_q;
  assign rot = go && ((instr_word & 12'hFC0) == 12'h300);
  assign slp = go && (instr_word == 12'h003);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rf;
    rot && instr_word[5] |=> file_we_q && file_wdata_q == {$past(carry_q), $past(file_rdata[7:1])};
  endproperty
  a_rf: assert property (p_rf) else $error("rotate to file wrong");
  property p_rw;
    rot && !instr_word[5] |=> working_we_q && !file_we_q && working_q == {$past(carry_q), $past(file_rdata[7:1])};
  endproperty
  a_rw: assert property (p_rw) else $error("rotate to working wrong");
  property p_ad; rot && instr_word[5] |=> file_waddr_q == $past(instr_word[4:0]); endproperty
  a_ad: assert property (p_ad) else $error("rotate address wrong");
  property p_cy; rot |=> carry_q == $past(file_rdata[0]); endproperty
  a_cy: assert property (p_cy) else $error("carry wrong");
  property p_to; slp |=> timeout_status_flag_q && !powerdown_status_flag_q; endproperty
  a_to: assert property (p_to) else $error("sleep flags wrong");
  property p_wd;
    slp |=> watchdog_counter_q == 8'h00 && watchdog_presc_q == 8'h00 ##1 watchdog_presc_q == 8'h00;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog not cleared");
  property p_wk; slp |=> wake_status_flag_q ##1 $stable(wake_status_flag_q); endproperty
  a_wk: assert property (p_wk) else $error("wake flag wrong");
  property p_hl; slp |=> halted_q && !osc_run_q ##1 !file_we_q && !working_we_q; endproperty
  a_hl: assert property (p_hl) else $error("sleep did not halt");
endmodule : rrs_exec_asserts

// *** verif/testbench.sv ***
/* Self-checking bench for rrs_exec: random words against an integer model.
   Assumes one 10 MHz clock and the checker bound below. */
`timescale 1ns/100ps
module testbench;
  logic        clk = 0, resetn = 0, instr_valid = 0, wake_event = 0;
  logic [11:0] instr_word = 12'h000;
  logic [7:0]  file_rdata = 8'h00, file_wdata_q, working_q, watchdog_counter_q, watchdog_presc_q;
  logic [4:0]  file_raddr, file_waddr_q;
  logic        file_we_q, working_we_q, carry_q, halted_q, osc_run_q;
  logic        timeout_status_flag_q, powerdown_status_flag_q, wake_status_flag_q;
  logic [31:0] x = 32'hAA5B;
  int          fails = 0, num_checks = 0, cycles = 0, pw = 0, pr = 0, pv = 0, mc = 0, res, i, k;
  always #50 clk = ~clk;
  rrs_exec rrs_exec_inst (.clk, .resetn, .instr_word, .instr_valid, .file_rdata, .wake_event, .file_raddr,
    .file_waddr_q, .file_wdata_q, .file_we_q, .working_q, .working_we_q, .carry_q, .timeout_status_flag_q,
    .powerdown_status_flag_q, .wake_status_flag_q, .watchdog_counter_q, .watchdog_presc_q, .halted_q, .osc_run_q);
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    next_rand = t ^ (t << 5);
  endfunction : next_rand
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Ceiling is about eight times the expected run, so only a hang reaches it.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(powerdown_status_flag_q === 1'b1 && osc_run_q === 1'b1 && halted_q === 1'b0,
        "reset state wrong");
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      x = next_rand(x);
      instr_word  <= (x[3:0] == 4'h0) ? 12'h003 : (x[3:0] < 4'hC) ? {6'h0C, x[9:4]} : x[21:10];
      file_rdata  <= x[29:22];
      instr_valid <= x[31:30] != 2'h0;
      @(negedge clk);
      chk(file_raddr === instr_word[4:0], "read address wrong");
      if (pv && (pw & 12'hFC0) == 12'h300) begin
        res = (mc << 7) | (pr >> 1);
        mc = pr & 1;
        k = (pw >> 5) & 1;
        chk(file_we_q === k[0] && working_we_q === !k[0] && carry_q === mc[0], "rotate strobe wrong");
        chk(k ? file_wdata_q === res[7:0] && file_waddr_q === pw[4:0] : working_q === res[7:0],
            "rotate result wrong");
      end else begin
        chk(file_we_q === 1'b0 && working_we_q === 1'b0, "stray write");
        if (pv && pw == 12'h003) begin
          chk(timeout_status_flag_q === 1'b1 && powerdown_status_flag_q === 1'b0, "sleep flags wrong");
          chk(watchdog_counter_q === 8'h00 && watchdog_presc_q === 8'h00, "watchdog not cleared");
          chk(wake_status_flag_q === 1'b1, "wake flag not set");
          chk(halted_q === 1'b1 && osc_run_q === 1'b0, "sleep did not halt");
          // The word already presented is sampled while asleep and must be dropped.
          @(posedge clk);
          instr_valid <= 1'b0;
          wake_event  <= 1'b1;
          @(negedge clk);
          chk(file_we_q === 1'b0 && working_we_q === 1'b0 && carry_q === mc[0], "word run while asleep");
          chk(watchdog_presc_q === 8'h00, "watchdog ran while asleep");
          for (k = 0; k < 8 && halted_q !== 1'b0; k++) @(negedge clk);
          chk(halted_q === 1'b0 && osc_run_q === 1'b1, "no wake");
          @(posedge clk);
          wake_event <= 1'b0;
        end
      end
      pw = instr_word;
      pr = file_rdata;
      pv = instr_valid;
    end
    conclude();
  end
endmodule : testbench
bind rrs_exec rrs_exec_asserts rrs_exec_asserts_inst (.clk, .resetn, .instr_valid, .instr_word, .file_rdata,
  .file_wdata_q, .working_q, .watchdog_counter_q, .watchdog_presc_q, .file_waddr_q, .file_we_q, .working_we_q,
  .carry_q, .halted_q, .osc_run_q, .timeout_status_flag_q, .powerdown_status_flag_q, .wake_status_flag_q);
